/* File: inc/csrsw_pkg.sv */
// package: register map, field layout and constants of the swap and rom header registers
//
// Operation
// - compare register at 10h, read-only
// - data register at 0Ch, read-only
// - done flag bit 31 set on completion
// - any control write clears done flag
// - selector bits 1-0 pick csr resource
// - bits 30-2 read zero; done resets set
// - header register at 18h, rom first quadlet
// - crc field loaded from eeprom if present
// - header upper sixteen bits reset zero
// - bus name register 1Ch returns 31333934h
package csrsw_pkg;
  localparam logic [7:0] CSRSW_OFS_DATA = 8'h0c;
  localparam logic [7:0] CSRSW_OFS_CMP = 8'h10;
  localparam logic [7:0] CSRSW_OFS_CTRL = 8'h14;
  localparam logic [7:0] CSRSW_OFS_HDR = 8'h18;
  localparam logic [7:0] CSRSW_OFS_BUSID = 8'h1c;
  localparam logic [7:0] CSRSW_OFS_CMP_WR = 8'h40;
  localparam logic [7:0] CSRSW_OFS_DATA_WR = 8'h44;
  localparam logic [7:0] CSRSW_OFS_RES = 8'h48;
  localparam logic [7:0] CSRSW_OFS_STAT = 8'h4c;
  localparam logic [31:0] CSRSW_BUS_NAME = 32'h31333934;
  localparam int CSRSW_DONE_BIT = 31;
  localparam logic [31:0] CSRSW_SEL_MASK = 32'h00000003;
  localparam logic [15:0] CSRSW_HDR_HI_RST = 16'h0000;
  localparam logic [15:0] CSRSW_CRC_RST = 16'h0000;
  localparam logic [31:0] CSRSW_ZERO = 32'h00000000;
  localparam logic [31:0] CSRSW_RES_RST = 32'h00000000;
  localparam int CSRSW_RES_NUM = 4;
  localparam logic [1:0] CSRSW_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] CSRSW_SWAP_BUSY_CYC = 2'h2;
  typedef enum logic [2:0] {
    CSRSW_IDLE = 3'b001,
    CSRSW_CMP = 3'b010,
    CSRSW_WAIT = 3'b100
  } csrsw_state_type;
endpackage : csrsw_pkg

/* File: hw/csrsw_res_file.sv */
// csr resource storage: four quadlets indexed by the selector
`timescale 1ns/10ps
`default_nettype none
module csrsw_res_file
  import csrsw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [1:0] i_sel,
  input wire logic i_we,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata
);
  logic [31:0] res_reg [CSRSW_RES_NUM];
  logic [31:0] res_next [CSRSW_RES_NUM];

  always_comb begin
    for (int i = 0; i < CSRSW_RES_NUM; i++) begin
      res_next[i] = res_reg[i];
    end
    if (i_we) begin
      res_next[i_sel] = i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < CSRSW_RES_NUM; i++) begin
        res_reg[i] <= CSRSW_RES_RST;
      end
    end else if (i_ce) begin
      for (int i = 0; i < CSRSW_RES_NUM; i++) begin
        res_reg[i] <= res_next[i];
      end
    end
  end

  assign o_rdata = res_reg[i_sel];
endmodule : csrsw_res_file
`default_nettype wire

/* File: hw/csrsw_regs.sv */
// top: ahb-lite register bank for compare-swap and rom header quadlets
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module csrsw_regs
  import csrsw_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  input wire logic I_EEPROM_PRESENT,
  input wire logic I_EEPROM_VALID,
  input wire logic [15:0] I_EEPROM_CRC,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [31:0] O_ROM_HEADER,
  output logic O_SWAP_COMPLETE
);
  import csrsw_pkg::*;

  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ready_reg, ready_next;
  logic addr_ok;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [31:0] cmp_reg, cmp_next;
  logic [31:0] data_reg, data_next;
  logic done_reg, done_next;
  logic [1:0] sel_reg, sel_next;
  logic [31:0] hdr_reg, hdr_next;
  logic eeprom_done_reg, eeprom_done_next;
  logic match_reg, match_next;
  csrsw_state_type state_reg, state_next;
  logic res_we;
  logic [31:0] res_rdata;
  logic ctrl_wr_w;

  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : is_ofs

  assign addr_ok = I_HSEL && I_HREADY && (I_HTRANS == CSRSW_HTRANS_NONSEQ);

  csrsw_res_file u_res (
    .i_clk(I_CLK_SYS),
    .i_rstn(I_RSTN),
    .i_ce(I_CE),
    .i_sel(sel_reg),
    .i_we(res_we),
    .i_wdata(data_reg),
    .o_rdata(res_rdata)
  );

  // ----------------------------------------
  // bus and register next state
  // ----------------------------------------
  always_comb begin
    logic ctrl_wr;
    ctrl_wr = 1'b0;
    wr_pend_next = 1'b0;
    rd_pend_next = 1'b0;
    addr_next = addr_reg;
    ready_next = 1'b1;
    rdata_next = rdata_reg;
    cmp_next = cmp_reg;
    data_next = data_reg;
    sel_next = sel_reg;
    hdr_next = hdr_reg;
    eeprom_done_next = eeprom_done_reg;
    if (addr_ok) begin
      wr_pend_next = I_HWRITE;
      rd_pend_next = !I_HWRITE;
      addr_next = I_HADDR[7:0];
      ready_next = I_HWRITE; // registered read data costs one wait state
    end
    if (rd_pend_reg) begin
      unique case (1'b1)
        is_ofs(addr_reg, CSRSW_OFS_DATA): rdata_next = data_reg;
        is_ofs(addr_reg, CSRSW_OFS_CMP): rdata_next = cmp_reg;
        is_ofs(addr_reg, CSRSW_OFS_CTRL): begin
          rdata_next = {done_reg, 29'h0, sel_reg};
        end
        is_ofs(addr_reg, CSRSW_OFS_HDR): rdata_next = hdr_reg;
        is_ofs(addr_reg, CSRSW_OFS_BUSID): rdata_next = CSRSW_BUS_NAME;
        is_ofs(addr_reg, CSRSW_OFS_RES): rdata_next = res_rdata;
        is_ofs(addr_reg, CSRSW_OFS_STAT): rdata_next = {31'h0, match_reg};
        default: rdata_next = CSRSW_ZERO;
      endcase
    end
    if (wr_pend_reg) begin
      unique case (1'b1)
        is_ofs(addr_reg, CSRSW_OFS_CTRL): begin
          ctrl_wr = 1'b1;
          sel_next = I_HWDATA[1:0];
        end
        is_ofs(addr_reg, CSRSW_OFS_HDR): hdr_next = I_HWDATA;
        is_ofs(addr_reg, CSRSW_OFS_CMP_WR): cmp_next = I_HWDATA;
        is_ofs(addr_reg, CSRSW_OFS_DATA_WR): data_next = I_HWDATA;
        default: ;
      endcase
    end
    // eeprom load only once, so later software writes to the crc field stick
    if (I_EEPROM_PRESENT && I_EEPROM_VALID && !eeprom_done_reg) begin
      hdr_next[15:0] = I_EEPROM_CRC;
      eeprom_done_next = 1'b1;
    end
    ctrl_wr_w = ctrl_wr;
  end

  // ----------------------------------------
  // compare-swap sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    done_next = done_reg;
    match_next = match_reg;
    res_we = 1'b0;
    unique case (state_reg)
      CSRSW_IDLE: begin
        if (ctrl_wr_w) begin
          done_next = 1'b0;
          state_next = CSRSW_CMP;
        end
      end
      CSRSW_CMP: begin
        // selector already updated, so compare against the new target
        match_next = (res_rdata == cmp_reg);
        res_we = (res_rdata == cmp_reg);
        state_next = CSRSW_WAIT;
        // a control write here restarts the swap, so no write is ever lost
        if (ctrl_wr_w) begin
          done_next = 1'b0;
          state_next = CSRSW_CMP;
        end
      end
      CSRSW_WAIT: begin
        done_next = 1'b1;
        state_next = CSRSW_IDLE;
        if (ctrl_wr_w) begin
          done_next = 1'b0;
          state_next = CSRSW_CMP;
        end
      end
      default: state_next = CSRSW_IDLE;
    endcase
  end

  // ----------------------------------------
  // sequencer registers
  // ----------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      done_reg <= 1'b1;
      match_reg <= 1'b0;
      state_reg <= CSRSW_IDLE;
    end else if (I_CE) begin
      done_reg <= done_next;
      match_reg <= match_next;
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // bus and register flops
  // ----------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= CSRSW_ZERO;
      ready_reg <= 1'b1;
      cmp_reg <= CSRSW_ZERO;
      data_reg <= CSRSW_ZERO;
      sel_reg <= 2'h0;
      hdr_reg <= {CSRSW_HDR_HI_RST, CSRSW_CRC_RST};
      eeprom_done_reg <= 1'b0;
    end else if (I_CE) begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
      ready_reg <= ready_next;
      cmp_reg <= cmp_next;
      data_reg <= data_next;
      sel_reg <= sel_next;
      hdr_reg <= hdr_next;
      eeprom_done_reg <= eeprom_done_next;
    end
  end

  // read data is registered, so the data phase needs one wait state
  assign O_HRDATA = rdata_reg;
  assign O_HREADYOUT = ready_reg;
  assign O_HRESP = 1'b0;
  assign O_ROM_HEADER = hdr_reg;
  assign O_SWAP_COMPLETE = done_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_done_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && wr_pend_reg && addr_reg == CSRSW_OFS_CTRL |=> !done_reg)
    else $error("done flag not cleared by control write");
  a_done_set: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && state_reg == CSRSW_CMP && !ctrl_wr_w ##1 I_CE && !ctrl_wr_w |=> done_reg)
    else $error("done flag not set after swap");
  a_swap_store: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && state_reg == CSRSW_CMP && !ctrl_wr_w && res_rdata == cmp_reg
    |=> res_rdata == $past(data_reg))
    else $error("swap data not stored on match");
  a_swap_keep: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && state_reg == CSRSW_CMP && res_rdata != cmp_reg |-> !res_we)
    else $error("resource written on mismatch");
  a_ctrl_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && rd_pend_reg && addr_reg == CSRSW_OFS_CTRL |=> O_HRDATA[30:2] == 29'h0)
    else $error("control reserved bits not zero");
  a_bus_name: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && rd_pend_reg && addr_reg == CSRSW_OFS_BUSID |=> O_HRDATA == CSRSW_BUS_NAME)
    else $error("bus name quadlet wrong");
  a_sel_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && wr_pend_reg && addr_reg == CSRSW_OFS_CTRL |=> sel_reg == $past(I_HWDATA[1:0]))
    else $error("selector not written");
  a_crc_load: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && I_EEPROM_PRESENT && I_EEPROM_VALID && !eeprom_done_reg
    |=> hdr_reg[15:0] == $past(I_EEPROM_CRC))
    else $error("crc not loaded from eeprom");
  a_rd_data: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && rd_pend_reg && addr_reg == CSRSW_OFS_CMP |=> O_HRDATA == $past(cmp_reg))
    else $error("compare readback wrong");
  c_swap_match: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    state_reg == CSRSW_CMP && res_rdata == cmp_reg);
  c_swap_miss: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    state_reg == CSRSW_CMP && res_rdata != cmp_reg);
  c_hdr_write: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    wr_pend_reg && addr_reg == CSRSW_OFS_HDR);
  a_data_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && rd_pend_reg && addr_reg == CSRSW_OFS_DATA |=> O_HRDATA == $past(data_reg))
    else $error("data readback wrong");
  a_hdr_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && rd_pend_reg && addr_reg == CSRSW_OFS_HDR |=> O_HRDATA == $past(hdr_reg))
    else $error("header readback wrong");
  a_hdr_write: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && wr_pend_reg && addr_reg == CSRSW_OFS_HDR
    && !(I_EEPROM_PRESENT && I_EEPROM_VALID && !eeprom_done_reg) |=> O_ROM_HEADER == $past(I_HWDATA))
    else $error("header write lost");
  a_done_rdback: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && rd_pend_reg && addr_reg == CSRSW_OFS_CTRL |=> O_HRDATA[CSRSW_DONE_BIT] == $past(done_reg))
    else $error("done flag readback wrong");
  a_sel_rdback: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && rd_pend_reg && addr_reg == CSRSW_OFS_CTRL |=> O_HRDATA[1:0] == $past(sel_reg))
    else $error("selector readback wrong");
  a_crc_once: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && eeprom_done_reg && !(wr_pend_reg && addr_reg == CSRSW_OFS_HDR)
    |=> O_ROM_HEADER[15:0] == $past(hdr_reg[15:0]))
    else $error("crc field changed without a write");
  a_read_wait: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    rd_pend_reg |-> !O_HREADYOUT)
    else $error("read data phase without wait state");
  a_write_nowait: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    wr_pend_reg |-> O_HREADYOUT)
    else $error("write data phase stalled");
  a_swap_busy: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    state_reg == CSRSW_CMP |-> !O_SWAP_COMPLETE)
    else $error("done flag high while swap pending");
  a_hresp_okay: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    !O_HRESP)
    else $error("error response driven");
  a_state_onehot: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    $onehot(state_reg))
    else $error("sequencer state not one-hot");
  a_cmp_ro: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && !(wr_pend_reg && addr_reg == CSRSW_OFS_CMP_WR)
    |=> cmp_reg == $past(cmp_reg))
    else $error("compare value changed without a write");
  a_data_ro: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && !(wr_pend_reg && addr_reg == CSRSW_OFS_DATA_WR)
    |=> data_reg == $past(data_reg))
    else $error("data value changed without a write");
  a_done_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && state_reg == CSRSW_IDLE && !ctrl_wr_w
    |=> O_SWAP_COMPLETE == $past(done_reg))
    else $error("done flag moved while idle");
  a_ce_freeze: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    !I_CE |=> state_reg == $past(state_reg) && done_reg == $past(done_reg)
    && sel_reg == $past(sel_reg))
    else $error("state moved with clock enable low");
  c_ctrl_restart: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    I_CE && state_reg == CSRSW_WAIT && ctrl_wr_w);
  c_ce_hold: cover property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    !I_CE && state_reg == CSRSW_CMP);
endmodule : csrsw_regs
`default_nettype wire

/* File: test/csrsw_regs_tb.sv */
// testbench: self-checking ahb-lite run over the swap and rom header registers
`timescale 1ns/10ps
`default_nettype none
module csrsw_regs_tb;
  import csrsw_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ep = 1'b1;
  logic ev = 1'b0;
  logic [15:0] ecrc = 16'h0;
  logic ce = 1'b1;
  logic [31:0] ov;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic hresp;
  wire logic [31:0] romh;
  wire logic done;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h55;
  logic [31:0] res [4];
  logic [31:0] rd;
  logic [31:0] nv;
  always #2.5 clk = ~clk;
  csrsw_regs u_dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .I_CE(ce), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hready), .I_EEPROM_PRESENT(ep), .I_EEPROM_VALID(ev),
    .I_EEPROM_CRC(ecrc), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .O_ROM_HEADER(romh), .O_SWAP_COMPLETE(done));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // sample ready before the edge so the design's own update at the edge is not raced
  task automatic wait_rdy();
    logic r;
    do begin
      @(negedge clk);
      r = hready;
      rd = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= CSRSW_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    chk({31'h0, hresp}, 32'h0);
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  // control write, then done must drop at once and come back after the busy cycles;
  // a nonzero f holds the clock enable low for f edges while the swap is pending
  task automatic swap(input logic [1:0] s, input int f);
    int n;
    bus(1'b1, CSRSW_OFS_CTRL, xs() & 32'h7ffffffc | {30'h0, s});
    if (f > 0) begin
      ce <= 1'b0;
      repeat (f) @(posedge clk);
      ce <= 1'b1;
    end
    #1 chk({31'h0, done}, 32'h0);
    n = 0;
    while (done !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    chk({31'h0, done}, 32'h1);
    chk(n, {30'h0, CSRSW_SWAP_BUSY_CYC});
    @(posedge clk);
  endtask : swap
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      finish_test();
    end
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rchk(CSRSW_OFS_CTRL, 32'h80000000);
    rchk(CSRSW_OFS_HDR, 32'h0);
    rchk(CSRSW_OFS_BUSID, CSRSW_BUS_NAME);
    rchk(8'h80, 32'h0);
    $display("reset test done");
    nv = xs();
    ecrc <= nv[15:0];
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    ecrc <= ~nv[15:0];
    rchk(CSRSW_OFS_HDR, {16'h0, nv[15:0]});
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
    rchk(CSRSW_OFS_HDR, {16'h0, nv[15:0]});
    nv = xs();
    bus(1'b1, CSRSW_OFS_HDR, nv);
    rchk(CSRSW_OFS_HDR, nv);
    chk(romh, nv);
    bus(1'b1, CSRSW_OFS_BUSID, xs());
    rchk(CSRSW_OFS_BUSID, CSRSW_BUS_NAME);
    $display("header test done");
    for (int i = 0; i < 4; i++) res[i] = 32'h0;
    for (int k = 0; k < 12; k++) begin
      logic [1:0] s;
      logic [31:0] c;
      logic [31:0] d;
      logic m;
      s = k[1:0];
      d = xs();
      c = (k >= 8) ? ~res[s] : res[s];
      bus(1'b1, CSRSW_OFS_CMP_WR, c);
      bus(1'b1, CSRSW_OFS_DATA_WR, d);
      bus(1'b1, CSRSW_OFS_CMP, xs());
      bus(1'b1, CSRSW_OFS_DATA, xs());
      swap(s, (k == 5) ? 3 : 0);
      m = (c === res[s]);
      if (m) res[s] = d;
      rchk(CSRSW_OFS_CTRL, {30'h20000000, s});
      rchk(CSRSW_OFS_CMP, c);
      rchk(CSRSW_OFS_DATA, d);
      rchk(CSRSW_OFS_RES, res[s]);
      rchk(CSRSW_OFS_STAT, {31'h0, m});
    end
    $display("swap test done");
    // a second control write lands while the first swap is finishing
    ov = res[1];
    nv = xs();
    bus(1'b1, CSRSW_OFS_CMP_WR, ov);
    bus(1'b1, CSRSW_OFS_DATA_WR, nv);
    bus(1'b1, CSRSW_OFS_CTRL, 32'h00000001);
    swap(2'h2, 0);
    res[1] = nv;
    if (res[2] === ov) res[2] = nv;
    rchk(CSRSW_OFS_RES, res[2]);
    bus(1'b1, CSRSW_OFS_CMP_WR, ~nv);
    swap(2'h1, 0);
    rchk(CSRSW_OFS_RES, nv);
    rchk(CSRSW_OFS_STAT, 32'h0);
    $display("restart test done");
    finish_test();
  end
endmodule : csrsw_regs_tb
`default_nettype wire
